// [verilog/acu_consts.svh]
// Register offsets, field positions, reset values and bus codes of the compare unit
`ifndef ACU_CONSTS_SVH
`define ACU_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ACU_SC_OFFSET      32'h0000_0000
`define ACU_SC_RESET       8'h00

// ----------------------------------------------------------------
// Field positions in the status and control register
// ----------------------------------------------------------------
`define ACU_BIT_ENABLE     7
`define ACU_BIT_REFSEL     6
`define ACU_BIT_FLAG       5
`define ACU_BIT_IRQEN      4
`define ACU_BIT_READBACK   3
`define ACU_BIT_PINEN      2
`define ACU_BIT_MODE_HI    1
`define ACU_BIT_MODE_LO    0

// ----------------------------------------------------------------
// Bus codes and timing
// ----------------------------------------------------------------
`define ACU_HTRANS_NONSEQ  2'h2
`define ACU_HSIZE_WORD     3'h2
`define ACU_SYNC_DEPTH     2

`endif

// [verilog/acu_pkg.sv]
// Types shared by the compare unit modules
package acu_pkg;

    // ----------------------------------------------------------------
    // Event type selection
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        EVT_FALL_A = 2'b00,
        EVT_RISE   = 2'b01,
        EVT_FALL_B = 2'b10,
        EVT_BOTH   = 2'b11
    } acu_evt_t;

    // ----------------------------------------------------------------
    // State of the synchroniser
    // ----------------------------------------------------------------
    typedef struct packed {
        logic meta;
        logic stable;
    } acu_sync_t;

    // ----------------------------------------------------------------
    // State of the control block
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr_pend;
        logic       hit_pend;
        logic       comparator_enable;
        logic       reference_source_select;
        logic       compare_event_flag;
        logic       compare_irq_enable;
        logic       result_readback;
        logic       result_pin_enable;
        acu_evt_t   event_type_select;
        logic       prev_result;
        logic       armed;
        logic [7:0] rdata;
    } acu_state_t;

endpackage : acu_pkg

// [verilog/acu_sync.sv]
// Two-stage synchroniser for the asynchronous comparator output
`include "acu_consts.svh"

module acu_sync (
    input  wire logic CLK,     // Bus clock
    input  wire logic RST,     // Synchronous reset
    input  wire logic ASYNC_IN, // Raw comparator level
    output logic      SYNC_OUT  // Level in the clock domain
);
    import acu_pkg::*;

    acu_sync_t st;
    acu_sync_t next_st;

    // ----------------------------------------------------------------
    // Stages
    // ----------------------------------------------------------------
    // First stage feeds only the second; nothing else looks at it
    always_comb begin
        next_st        = st;
        next_st.meta   = ASYNC_IN;
        next_st.stable = st.meta;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign SYNC_OUT = st.stable;

endmodule : acu_sync

// [verilog/acu_top.sv]
// Analog compare unit control logic with AHB-Lite register slave
//
// Summary of operation
// - Enabled comparator and event logic keep running through wait mode.
// - In wait mode a compare interrupt wakes the processor, only if enabled.
// - Any stop mode switches the comparator off whatever its settings.
// - No compare event, interrupt or wake-up comes out of a stop mode.
// - Deep stop powers the unit down; it wakes in its reset state.
// - Light stop halts the unit's clocking and keeps every register bit; the two acu_sync stages keep sampling.
// - Light stop performs no compare; flag and readback do not change.
// - Leaving light stop by reset returns the unit to reset state.
// - Leaving light stop by interrupt resumes from the held state.
// - Background debug mode does not freeze the unit.
// - Inverting input always comes from the minus input pin.
// - Non-inverting input is plus pin when select is 0, else bandgap.
// - Result drives the output pin only when the pin enable is set.
// - Interrupt source may respond to rising, falling or both edges.
// - Event mode 00 falling, 01 rising, 10 falling, 11 either edge.
// - Flag sets on the selected event, clears only by writing one.
// - Interrupt request is high while flag and interrupt enable are set.
// - Readback shows live result; zero after reset and while disabled.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`include "acu_consts.svh"

module acu_top (
    input  wire logic        CLK,                  // Bus clock, 100 MHz
    input  wire logic        RST,                  // Synchronous reset
    input  wire logic        HSEL,                 // Slave select
    input  wire logic [31:0] HADDR,                // Byte address
    input  wire logic [1:0]  HTRANS,               // Transfer type
    input  wire logic        HWRITE,               // Write access
    input  wire logic [2:0]  HSIZE,                // Transfer size
    input  wire logic [31:0] HWDATA,               // Write data
    input  wire logic        HREADY,               // Bus ready
    output logic      [31:0] HRDATA,               // Read data
    output logic             HREADYOUT,            // Slave ready
    output logic             HRESP,                // Always OKAY
    input  wire logic        PLUS_ABOVE_MINUS,     // Plus pin above minus pin
    input  wire logic        BANDGAP_ABOVE_MINUS,  // Bandgap above minus pin
    input  wire logic        WAIT_MODE,            // Processor in wait
    input  wire logic        LIGHT_STOP_MODE,      // Light stop active
    input  wire logic        DEEP_STOP_MODE,       // Deep stop active
    output logic             COMPARATOR_POWER,     // Analog comparator on
    output logic             REFERENCE_SELECT,     // Non-inverting source
    output logic             COMPARE_RESULT_PIN,   // Result pin data
    output logic             RESULT_PIN_OE,        // Result pin driven
    output logic             COMPARE_IRQ,          // Interrupt request
    output logic             WAKE_REQ              // Wake from wait
);
    import acu_pkg::*;

    acu_state_t st;
    acu_state_t next_st;

    logic run;
    logic cmp_selected;
    logic sync_result;
    logic rise_evt;
    logic fall_evt;
    logic hit_evt;
    logic addr_ok;
    logic clr_flag;
    logic wr_now;

    // ----------------------------------------------------------------
    // Analog front end
    // ----------------------------------------------------------------
    // Both comparisons use the minus pin as inverting input
    assign cmp_selected = st.reference_source_select ?
                          BANDGAP_ABOVE_MINUS : PLUS_ABOVE_MINUS;

    // Clocks halted in either stop; debug mode has no input here
    assign run = !LIGHT_STOP_MODE && !DEEP_STOP_MODE;

    acu_sync acu_sync_inst (
        .CLK      (CLK),
        .RST      (RST),
        .ASYNC_IN (cmp_selected),
        .SYNC_OUT (sync_result)
    );

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    // Armed only after a full enabled cycle, so enabling never
    // fakes an edge from a stale previous sample
    assign rise_evt = st.armed && sync_result && !st.prev_result;
    assign fall_evt = st.armed && !sync_result && st.prev_result;

    always_comb begin
        unique case (st.event_type_select)
            EVT_FALL_A: hit_evt = fall_evt;
            EVT_RISE:   hit_evt = rise_evt;
            EVT_FALL_B: hit_evt = fall_evt;
            EVT_BOTH:   hit_evt = rise_evt || fall_evt;
        endcase
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign addr_ok  = HSEL && HREADY && (HTRANS == `ACU_HTRANS_NONSEQ)
                      && (HSIZE == `ACU_HSIZE_WORD);
    assign wr_now   = st.wr_pend && st.hit_pend;
    assign clr_flag = wr_now && HWDATA[`ACU_BIT_FLAG];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (DEEP_STOP_MODE) begin
            // Powered down: wakes in the reset state
            next_st                   = '0;
            next_st.event_type_select = EVT_FALL_A;
        end else if (LIGHT_STOP_MODE) begin
            // Everything held; an interrupt exit resumes from here
            next_st = st;
        end else begin
            // Address phase: unmapped or odd-sized accesses are ignored
            next_st.wr_pend  = addr_ok && HWRITE;
            next_st.hit_pend = addr_ok && (HADDR == `ACU_SC_OFFSET);

            // Data phase write
            if (wr_now) begin
                next_st.comparator_enable       = HWDATA[`ACU_BIT_ENABLE];
                next_st.reference_source_select = HWDATA[`ACU_BIT_REFSEL];
                next_st.compare_irq_enable      = HWDATA[`ACU_BIT_IRQEN];
                next_st.result_pin_enable       = HWDATA[`ACU_BIT_PINEN];
                next_st.event_type_select       =
                    acu_evt_t'(HWDATA[`ACU_BIT_MODE_HI:`ACU_BIT_MODE_LO]);
            end

            // Set wins over a write-one clear in the same cycle
            if (st.comparator_enable && hit_evt) begin
                next_st.compare_event_flag = 1'b1;
            end else if (clr_flag) begin
                next_st.compare_event_flag = 1'b0;
            end

            // Enabled unit keeps running through wait
            next_st.prev_result     = sync_result;
            next_st.armed           = st.comparator_enable &&
                                      next_st.comparator_enable;
            next_st.result_readback = next_st.comparator_enable &&
                                      sync_result;

            // Read data from the updated value covers read after write
            if (addr_ok && !HWRITE && (HADDR == `ACU_SC_OFFSET)) begin
                next_st.rdata = {next_st.comparator_enable,
                                 next_st.reference_source_select,
                                 next_st.compare_event_flag,
                                 next_st.compare_irq_enable,
                                 next_st.result_readback,
                                 next_st.result_pin_enable,
                                 next_st.event_type_select};
            end else begin
                next_st.rdata = `ACU_SC_RESET;
            end
        end
    end

    // Reset also covers leaving light stop by reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign HRDATA    = {24'h00_0000, st.rdata};
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // Comparator forced off in any stop
    assign COMPARATOR_POWER   = st.comparator_enable && run;
    assign REFERENCE_SELECT   = st.reference_source_select;
    assign COMPARE_RESULT_PIN = st.result_readback;
    assign RESULT_PIN_OE      = st.result_pin_enable &&
                                st.comparator_enable && run;

    // No request while stopped, so no wake from stop
    assign COMPARE_IRQ = st.compare_event_flag &&
                         st.compare_irq_enable && run;
    assign WAKE_REQ    = WAIT_MODE && COMPARE_IRQ;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // ----------------------------------------------------------------
    // Event, flag, readback, stop, pin and write checks
    // ----------------------------------------------------------------

    chk_rise_sets_flag: assert property (
        run && st.comparator_enable &&
        (st.event_type_select == EVT_RISE) && rise_evt
        |=> st.compare_event_flag)
        else $error("Rising event did not set the flag");

    chk_rise_mode_quiet: assert property (
        run && !st.compare_event_flag &&
        (st.event_type_select == EVT_RISE) && fall_evt
        |=> !st.compare_event_flag)
        else $error("Falling edge set flag in rising mode");

    chk_flag_sticky: assert property (
        st.compare_event_flag && !clr_flag && !DEEP_STOP_MODE
        |=> st.compare_event_flag)
        else $error("Flag cleared without a write of one");

    chk_flag_clear: assert property (
        run && clr_flag && !(st.comparator_enable && hit_evt)
        |=> !st.compare_event_flag)
        else $error("Write of one did not clear the flag");

    chk_irq_follow: assert property (
        run && st.compare_event_flag && st.compare_irq_enable
        |-> COMPARE_IRQ ##1 (COMPARE_IRQ || !run || $past(clr_flag) ||
                             !st.compare_irq_enable))
        else $error("Interrupt request missing");

    chk_readback_zero: assert property (
        !st.comparator_enable |-> !st.result_readback &&
                                  !COMPARE_RESULT_PIN)
        else $error("Readback nonzero while disabled");

    chk_sync_delay: assert property (
        (run && st.comparator_enable)[*4]
        |-> st.result_readback == $past(cmp_selected, 3))
        else $error("Readback not three cycles behind comparator");

    chk_light_hold: assert property (
        LIGHT_STOP_MODE && !DEEP_STOP_MODE |=> $stable(st))
        else $error("State changed during light stop");

    chk_deep_reset: assert property (
        DEEP_STOP_MODE |=> (st == '0))
        else $error("Deep stop did not restore reset state");

    chk_stop_silent: assert property (
        !run |-> !COMPARE_IRQ && !COMPARATOR_POWER && !WAKE_REQ)
        else $error("Comparator active during stop");

    chk_pin_gate: assert property (
        !st.result_pin_enable |-> !RESULT_PIN_OE)
        else $error("Result pin driven while disabled");

    chk_wait_wake: assert property (
        WAIT_MODE && st.compare_event_flag && st.compare_irq_enable && run
        |-> WAKE_REQ)
        else $error("No wake from wait on enabled interrupt");

    chk_write_lands: assert property (
        run && wr_now |=> st.comparator_enable == $past(HWDATA[`ACU_BIT_ENABLE]))
        else $error("Register write lost");

    chk_fall_sets_flag: assert property (
        run && st.comparator_enable && fall_evt &&
        ((st.event_type_select == EVT_FALL_A) ||
         (st.event_type_select == EVT_FALL_B))
        |=> st.compare_event_flag)
        else $error("Falling event did not set the flag");

    chk_both_sets_flag: assert property (
        run && st.comparator_enable &&
        (st.event_type_select == EVT_BOTH) && (rise_evt || fall_evt)
        |=> st.compare_event_flag)
        else $error("Edge did not set the flag in either-edge mode");

    chk_fall_mode_quiet: assert property (
        run && !st.compare_event_flag && rise_evt &&
        ((st.event_type_select == EVT_FALL_A) ||
         (st.event_type_select == EVT_FALL_B))
        |=> !st.compare_event_flag)
        else $error("Rising edge set flag in falling mode");

    chk_off_no_set: assert property (
        !st.comparator_enable && !st.compare_event_flag
        |=> !st.compare_event_flag)
        else $error("Flag set while comparator disabled");

    // ----------------------------------------------------------------
    // Mode, pin and bus checks
    // ----------------------------------------------------------------

    chk_wait_runs: assert property (
        WAIT_MODE && run && st.comparator_enable |-> COMPARATOR_POWER)
        else $error("Comparator off during wait");

    chk_wake_cause: assert property (
        WAKE_REQ |-> WAIT_MODE && st.compare_irq_enable &&
                     st.compare_event_flag)
        else $error("Wake request without enabled interrupt");

    chk_pin_data: assert property (
        RESULT_PIN_OE |-> COMPARE_RESULT_PIN == st.result_readback)
        else $error("Result pin does not carry the result");

    chk_deep_wake: assert property (
        $fell(DEEP_STOP_MODE) |-> (HRDATA == 32'h0000_0000) &&
                                  !COMPARE_IRQ && !COMPARATOR_POWER)
        else $error("Unit not in reset state after deep stop");

    chk_light_resume: assert property (
        $fell(LIGHT_STOP_MODE) && !$past(DEEP_STOP_MODE) |-> $stable(st))
        else $error("State moved on leaving light stop");

    chk_rdata_idle: assert property (
        !$past(addr_ok && !HWRITE) && !$past(LIGHT_STOP_MODE)
        |-> (HRDATA == 32'h0000_0000))
        else $error("Read data outside a read data phase");

    chk_bus_okay: assert property (
        HREADYOUT && !HRESP)
        else $error("Bus answer not ready and okay");

    // ----------------------------------------------------------------
    // Cover points
    // ----------------------------------------------------------------

    cov_rise_flag: cover property (
        (st.event_type_select == EVT_RISE) && rise_evt ##1
        st.compare_event_flag);

    cov_both_edges: cover property (
        (st.event_type_select == EVT_BOTH) && fall_evt ##1
        st.compare_event_flag);

    cov_wait_wake: cover property (WAIT_MODE && WAKE_REQ);

    cov_light_resume: cover property (
        st.compare_event_flag && LIGHT_STOP_MODE ##1 !LIGHT_STOP_MODE);

    cov_set_vs_clear: cover property (
        run && clr_flag && st.comparator_enable && hit_evt);

endmodule : acu_top

// [bench/acu_analog_model.sv]
// Behavioural model of the comparator's analog pins and bandgap reference
module acu_analog_model #(
    parameter logic [3:0] BANDGAP_LEVEL = 4'h8  // Plain default reference level
) (
    input  wire logic       clk,         // Bench clock, drives the unsettled pattern
    input  wire logic [3:0] plus_v,      // Plus input pin level
    input  wire logic [3:0] minus_v,     // Minus input pin level
    input  wire logic       bandgap_buffer_enable, // Bandgap buffer enable
    output logic            plus_above,  // Plus pin above minus pin
    output logic            bg_above     // Bandgap above minus pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic wobble;

    initial wobble = 1'b0;
    always @(posedge clk) wobble <= ~wobble;

    // Minus pin is the reference of both comparisons
    assign plus_above = plus_v > minus_v;
    // Unbuffered bandgap gives no usable level, so the answer keeps changing
    assign bg_above = bandgap_buffer_enable ? (BANDGAP_LEVEL > minus_v) : wobble;
endmodule : acu_analog_model

// [bench/analog_compare_control_tb.sv]
// Self-checking bench of the analog compare unit control logic
`include "acu_consts.svh"
`define CHK(nm, ex, gt) begin \
    n_checks++; \
    if ((gt) !== (ex)) begin \
        miscompares++; \
        $display("MISMATCH %s exp=%h got=%h", nm, ex, gt); \
    end \
end

module analog_compare_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] A  = `ACU_SC_OFFSET;
    localparam logic [7:0]  EN = 8'h80, RS = 8'h40, FL = 8'h20, IE = 8'h10, RB = 8'h08, PE = 8'h04;

    logic        clk, rst, hsel, hwrite, wait_m, lstop, dstop, bandgap_buffer_enable, ef;
    logic [2:0]  wsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  plus_v, minus_v;
    logic        hreadyout, hresp, plus_above, bg_above;
    logic        power, refsel_o, res_pin, res_oe, irq, wake;
    logic [7:0]  rd, ctl;
    int          miscompares, n_checks;

    // ----------------------------------------------------------------
    // Clock, design and analog model
    // ----------------------------------------------------------------
    initial clk = 1'b0;
    always #5 clk = ~clk;

    acu_top acu_top_inst (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .PLUS_ABOVE_MINUS(plus_above),
        .BANDGAP_ABOVE_MINUS(bg_above), .WAIT_MODE(wait_m), .LIGHT_STOP_MODE(lstop),
        .DEEP_STOP_MODE(dstop), .COMPARATOR_POWER(power), .REFERENCE_SELECT(refsel_o),
        .COMPARE_RESULT_PIN(res_pin), .RESULT_PIN_OE(res_oe), .COMPARE_IRQ(irq),
        .WAKE_REQ(wake));

    acu_analog_model acu_analog_model_inst (.clk(clk), .plus_v(plus_v), .minus_v(minus_v),
        .bandgap_buffer_enable(bandgap_buffer_enable),
        .plus_above(plus_above), .bg_above(bg_above));

    // ----------------------------------------------------------------
    // Bus tasks; each is entered just after a rising edge
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) miscompares++;
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= `ACU_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= wsize;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        wait_ready();
        rd = hrdata[7:0];
        `CHK("hresp", 1'b0, hresp)
        if (!wr) `CHK("hrdata_hi", 24'h00_0000, hrdata[31:8])
    endtask : bus

    task automatic wr(input logic [7:0] d);
        bus(1'b1, A, d);
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [7:0] ex, input string nm);
        bus(1'b0, a, 8'h00);
        `CHK(nm, ex, rd)
    endtask : rd_chk

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {hsel, hwrite, wait_m, lstop, dstop, bandgap_buffer_enable} = '0;
        wsize = `ACU_HSIZE_WORD;
        haddr = '0;
        hwdata = '0;
        htrans = '0;
        hsize = '0;
        plus_v = 4'h2;
        minus_v = 4'h5;
        miscompares = 0;
        n_checks = 0;
        rst = 1'b1;
        tick(20);
        rst <= 1'b0;
        tick(1);
        rd_chk(A, `ACU_SC_RESET, "reset_reg");
        `CHK("irq_rst", 1'b0, irq)
        // Every event mode, run inside wait so events must keep working there
        // Wait entered with the interrupt still disabled, so no wake during the loop
        wait_m <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            ctl = EN | PE | 8'(m);
            wr(ctl | FL);
            plus_v <= 4'h9;
            tick(6);
            ef = (m == 1 || m == 3);
            rd_chk(A, ctl | RB | (ef ? FL : 8'h00), "flag_rise");
            `CHK("pin_rise", 1'b1, res_pin)
            `CHK("oe_on", 1'b1, res_oe)
            wr(ctl);
            rd_chk(A, ctl | RB | (ef ? FL : 8'h00), "flag_kept");
            wr(ctl | FL);
            plus_v <= 4'h2;
            tick(6);
            rd_chk(A, ctl | ((m != 1) ? FL : 8'h00), "flag_fall");
        end
        `CHK("irq_off", 1'b0, irq)
        `CHK("wake_off", 1'b0, wake)
        wr(EN | IE | PE | 8'h03);
        tick(1);
        `CHK("irq_on", 1'b1, irq)
        `CHK("wake_on", 1'b1, wake)
        plus_v <= 4'h9;
        tick(6);
        // Light stop freezes everything, then resumes where it was
        lstop <= 1'b1;
        tick(2);
        `CHK("pwr_stop", 1'b0, power)
        `CHK("oe_stop", 1'b0, res_oe)
        `CHK("irq_stop", 1'b0, irq)
        `CHK("wake_stop", 1'b0, wake)
        plus_v <= 4'h2;
        tick(6);
        `CHK("pin_stop", 1'b1, res_pin)
        plus_v <= 4'h9;
        tick(6);
        lstop <= 1'b0;
        tick(1);
        rd_chk(A, EN | FL | IE | RB | PE | 8'h03, "resume_reg");
        `CHK("irq_resume", 1'b1, irq)
        `CHK("pwr_resume", 1'b1, power)
        // Deep stop wakes in the reset state
        dstop <= 1'b1;
        tick(2);
        dstop <= 1'b0;
        tick(1);
        rd_chk(A, 8'h00, "deep_wake");
        `CHK("irq_deep", 1'b0, irq)
        // Bandgap as non-inverting source; falling mode so enabling sets nothing
        wait_m <= 1'b0;
        bandgap_buffer_enable <= 1'b1;
        plus_v <= 4'h2;
        wr(EN | RS);
        tick(6);
        rd_chk(A, EN | RS | RB, "bandgap_sel");
        `CHK("refsel_pin", 1'b1, refsel_o)
        `CHK("oe_off", 1'b0, res_oe)
        minus_v <= 4'hC;
        tick(6);
        rd_chk(A, EN | RS | FL, "minus_pin");
        minus_v <= 4'h5;
        wr(FL);
        tick(6);
        rd_chk(A, 8'h00, "rb_disabled");
        rd_chk(32'h0000_0004, 8'h00, "unmapped");
        // Byte-sized write is refused and leaves the register alone
        wsize = 3'h0;
        wr(EN);
        wsize = `ACU_HSIZE_WORD;
        rd_chk(A, 8'h00, "size_refused");
        // Reset while in light stop overrides the freeze
        wr(EN | PE);
        lstop <= 1'b1;
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        lstop <= 1'b0;
        tick(1);
        rd_chk(A, 8'h00, "stop_reset");
        final_report();
    end

    // Tests need about two hundred cycles; this margin only catches a hang
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule : analog_compare_control_tb
